// >>> logic/dsc_cfg.svh
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
// register byte addresses
`define DSC_ADDR_DIR      16'hff22
`define DSC_ADDR_APC      16'hff8f
`define DSC_ADDR_DLYEN    16'hfa26
`define DSC_ADDR_DLY      16'hfa27
`define DSC_ADDR_CTL0     16'hff60
`define DSC_ADDR_CTL1     16'hff61
`define DSC_ADDR_SARSEL   16'hff31
`define DSC_ADDR_RES_L    16'hff62
`define DSC_ADDR_RES_H    16'hff63
// reset values
`define DSC_RST_DIR       8'hff
`define DSC_RST_APC       8'h08
`define DSC_RST_DLYEN     8'h00
`define DSC_RST_DLY       8'h20
`define DSC_RST_CTL       8'h00
// field positions
`define DSC_CTL0_PON      7
`define DSC_CTL0_CE       6
`define DSC_CTL0_BUSY     5
`define DSC_CTL1_DIFF     0
`define DSC_CTL1_HIACC    1
`define DSC_CTL1_PAR      2
`define DSC_DLYEN_BIT     7
`define DSC_DLY_LSB       4
`define DSC_DLY_MSB       6
`define DSC_APC_ALLDIG    4'h8
`define DSC_HALF_SCALE    16'h8000
// timing
`define DSC_CLK_NS        25
`define DSC_PON_SETTLE_NS 1200
`define DSC_PON_CYCLES    ((`DSC_PON_SETTLE_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`endif

// >>> logic/dsc_pkg.sv
package dsc_pkg;
  typedef enum logic {DSC_IDLE, DSC_CONV} dsc_state_e;
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } dsc_bus_s;
  typedef struct packed {
    logic diff;
    logic hi_acc;
    logic parallel;
  } dsc_mode_s;
endpackage

// >>> logic/dsc_top.sv
`timescale 1ns/1ps
`include "dsc_cfg.svh"
// Behaviour
// - direction bit 0 output, 1 input
// - reset loads direction register all ones
// - output-mode pin never analog input
// - pin converted only when exactly one converter selects it
// - enable starts conversion; 1.2 us guarantee
// - each end stores result, raises interrupt
// - repeats while enabled; clearing stops
// - power bit cleared powers converter off
// - pin change mid-conversion discards results
// - differential or single-ended input mode
// - switchable high-accuracy mode
// - parallel later conversions take quarter time
// - results are sixteen bits wide
// - differential zero gives half-scale code
// - read in end cycle sees old result
// - control zero or pin-config write suppresses end
module dsc_top
  import dsc_pkg::*;
#(
  parameter int CONV_CYCLES = 256
) (
  input  wire logic      clk,
  input  wire logic      reset,
  input  wire dsc_bus_s  bus,
  output logic [7:0]     rdata_q,
  input  wire logic [15:0] sample_code,
  output logic [7:0]     pin_out_en_q,
  output logic [7:0]     sar_pin_sel_q,
  output logic [7:0]     ds_pin_sel_q,
  output logic           neg_pin_ground_q,
  output dsc_mode_s      mode_q,
  output logic           pwr_on_q,
  output logic [2:0]     sampling_delay_q,
  output logic           conversion_done_irq_q,
  output logic           result_guaranteed_q
);
  localparam logic [7:0]  DLY_RST  = `DSC_RST_DLY;
  localparam logic [7:0]  CTL_RST  = `DSC_RST_CTL;
  localparam logic [7:0]  APC_RST  = `DSC_RST_APC;
  localparam logic [15:0] CNT_FULL = 16'(CONV_CYCLES - 1);
  localparam logic [15:0] CNT_QTR  = 16'(CONV_CYCLES / 4 - 1);
  localparam logic [7:0]  PON_CNT  = 8'(`DSC_PON_CYCLES);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  dir_q;
  logic [3:0]  apc_q;
  logic        dlyen_q;
  logic [2:0]  dly_q;
  logic        pon_q;
  logic        ce_q;
  logic [1:0]  chan_q;
  dsc_mode_s   ctl1_q;
  logic [2:0]  sar_q;
  logic [15:0] result_q;
  dsc_state_e  st_q;
  logic [15:0] cnt_q;
  logic        first_q;
  logic        stale_q;
  logic [7:0]  pon_cnt_q;

  logic wr_dir, wr_apc, wr_ctl0, wr_ctl1, wr_sar;
  assign wr_dir  = bus.wr && bus.addr == `DSC_ADDR_DIR;
  assign wr_apc  = bus.wr && bus.addr == `DSC_ADDR_APC;
  assign wr_ctl0 = bus.wr && bus.addr == `DSC_ADDR_CTL0;
  assign wr_ctl1 = bus.wr && bus.addr == `DSC_ADDR_CTL1;
  assign wr_sar  = bus.wr && bus.addr == `DSC_ADDR_SARSEL;
  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_q <= `DSC_RST_DIR;
    end else if (wr_dir) begin
      dir_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      apc_q   <= APC_RST[3:0];
      sar_q   <= CTL_RST[2:0];
      ctl1_q  <= CTL_RST[2:0];
    end else begin
      if (wr_apc) apc_q <= bus.wdata[3:0];
      if (wr_sar) sar_q <= bus.wdata[2:0];
      // mode is stable for a conversion only if software keeps off it while busy
      if (wr_ctl1) ctl1_q <= {bus.wdata[`DSC_CTL1_DIFF], bus.wdata[`DSC_CTL1_HIACC],
                              bus.wdata[`DSC_CTL1_PAR]};
    end
  end
  // delay setting only lands while its enable is set; byte-wide port only
  always_ff @(posedge clk) begin
    if (reset) begin
      dlyen_q <= 1'b0;
      dly_q   <= DLY_RST[`DSC_DLY_MSB:`DSC_DLY_LSB];
    end else begin
      if (bus.wr && bus.addr == `DSC_ADDR_DLYEN) dlyen_q <= bus.wdata[`DSC_DLYEN_BIT];
      if (bus.wr && bus.addr == `DSC_ADDR_DLY && dlyen_q) begin
        dly_q <= bus.wdata[`DSC_DLY_MSB:`DSC_DLY_LSB];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pon_q  <= CTL_RST[`DSC_CTL0_PON];
      ce_q   <= CTL_RST[`DSC_CTL0_CE];
      chan_q <= CTL_RST[1:0];
    end else if (wr_ctl0) begin
      pon_q  <= bus.wdata[`DSC_CTL0_PON];
      ce_q   <= bus.wdata[`DSC_CTL0_CE];
      chan_q <= bus.wdata[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin function decode
  logic [8:0] dig_w;
  logic [7:0] ana_w, chan_m, sar_m;
  assign dig_w  = (apc_q > `DSC_APC_ALLDIG) ? 9'h1ff : 9'((9'h1 << apc_q) - 9'h1);
  assign ana_w  = ~dig_w[7:0];
  assign chan_m = (chan_q == 2'h3) ? 8'h00 : 8'(8'h03 << {chan_q, 1'b0});
  assign sar_m  = 8'(8'h01 << sar_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out_en_q  <= 8'h00;
      sar_pin_sel_q <= 8'h00;
      ds_pin_sel_q  <= 8'h00;
    end else begin
      pin_out_en_q  <= ~dir_q;
      // a pin both converters claim goes to neither; output mode never analog
      sar_pin_sel_q <= ana_w & dir_q & sar_m & ~chan_m;
      ds_pin_sel_q  <= ana_w & dir_q & chan_m & ~sar_m;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_on_q         <= 1'b0;
      mode_q           <= '0;
      neg_pin_ground_q <= 1'b0;
      sampling_delay_q <= DLY_RST[`DSC_DLY_MSB:`DSC_DLY_LSB];
    end else begin
      pwr_on_q         <= pon_q;
      mode_q           <= ctl1_q;
      neg_pin_ground_q <= ~ctl1_q.diff;
      sampling_delay_q <= dly_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  logic pin_chg, end_w, store;
  assign pin_chg = (st_q == DSC_CONV) &&
                   ((wr_dir && |((bus.wdata ^ dir_q) & chan_m)) || wr_apc ||
                    (wr_ctl0 && bus.wdata[1:0] != chan_q) ||
                    (wr_sar && bus.wdata[2:0] != sar_q));
  assign end_w = (st_q == DSC_CONV) && ce_q && cnt_q == 16'h0000;
  assign store = end_w && !stale_q && !pin_chg && !wr_ctl0 && !wr_apc;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q    <= DSC_IDLE;
      cnt_q   <= 16'h0000;
      first_q <= 1'b0;
    end else if (!ce_q) begin
      st_q <= DSC_IDLE;
    end else begin
      unique case (st_q)
        DSC_IDLE: begin
          st_q    <= DSC_CONV;
          cnt_q   <= CNT_FULL;
          first_q <= 1'b1;
        end
        DSC_CONV: begin
          if (cnt_q == 16'h0000) begin
            cnt_q   <= ctl1_q.parallel ? CNT_QTR : CNT_FULL;
            first_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end
  // once pins move, nothing is stored until software restarts the sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      stale_q <= 1'b0;
    end else begin
      stale_q <= pin_chg | (stale_q & ce_q);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pon_cnt_q           <= 8'h00;
      result_guaranteed_q <= 1'b0;
    end else begin
      if (!pon_q) pon_cnt_q <= 8'h00;
      else if (pon_cnt_q != PON_CNT) pon_cnt_q <= pon_cnt_q + 8'h01;
      if (st_q == DSC_IDLE && ce_q) begin
        result_guaranteed_q <= pon_q && pon_cnt_q == PON_CNT;
      end
    end
  end
  // offset binary in differential mode puts zero input at half scale
  always_ff @(posedge clk) begin
    if (reset) begin
      result_q              <= 16'h0000;
      conversion_done_irq_q <= 1'b0;
    end else begin
      conversion_done_irq_q <= store;
      if (store) begin
        result_q <= ctl1_q.diff ? (sample_code ^ `DSC_HALF_SCALE) : sample_code;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // read port sees the value before any same-cycle update
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `DSC_ADDR_DIR:    rdata_q <= dir_q;
        `DSC_ADDR_APC:    rdata_q <= {4'h0, apc_q};
        `DSC_ADDR_DLYEN:  rdata_q <= {dlyen_q, 7'h00};
        `DSC_ADDR_DLY:    rdata_q <= {1'b0, dly_q, 4'h0};
        `DSC_ADDR_CTL0:   rdata_q <= {pon_q, ce_q, st_q == DSC_CONV, 3'h0, chan_q};
        `DSC_ADDR_CTL1:   rdata_q <= {5'h00, ctl1_q.parallel, ctl1_q.hi_acc, ctl1_q.diff};
        `DSC_ADDR_SARSEL: rdata_q <= {5'h00, sar_q};
        `DSC_ADDR_RES_L:  rdata_q <= result_q[7:0];
        `DSC_ADDR_RES_H:  rdata_q <= result_q[15:8];
        default:          rdata_q <= 8'h00;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // the second edge shows the reset direction value through the pin decode
  property p_dir_reset;
    @(posedge clk) $fell(reset) |-> pin_out_en_q == 8'h00 ##1 pin_out_en_q == 8'h00;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("pins not inputs after reset");
  property p_dir_out;
    @(posedge clk) disable iff (reset)
      wr_dir ##1 !reset |=> pin_out_en_q == ~$past(bus.wdata, 2);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("output enable not from direction");
  property p_no_out_analog;
    @(posedge clk) disable iff (reset) ((ds_pin_sel_q | sar_pin_sel_q) & pin_out_en_q) == 8'h00;
  endproperty
  a_no_out_analog: assert property (p_no_out_analog) else $error("output pin analog");
  property p_excl;
    @(posedge clk) disable iff (reset) (ds_pin_sel_q & sar_pin_sel_q) == 8'h00;
  endproperty
  a_excl: assert property (p_excl) else $error("pin claimed by both converters");
  sequence s_end_stored;
    store ##1 conversion_done_irq_q;
  endsequence
  property p_store;
    @(posedge clk) disable iff (reset)
      store |-> s_end_stored ##0 (result_q == ($past(ctl1_q.diff) ?
        ($past(sample_code) ^ `DSC_HALF_SCALE) : $past(sample_code)));
  endproperty
  a_store: assert property (p_store) else $error("end without result and irq");
  property p_stop;
    @(posedge clk) disable iff (reset) !ce_q |=> st_q == DSC_IDLE ##1 !conversion_done_irq_q;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion kept running");
  property p_pwr;
    @(posedge clk) disable iff (reset)
      wr_ctl0 && !bus.wdata[`DSC_CTL0_PON] |=> ##1 !pwr_on_q;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power not removed");
  property p_chg;
    @(posedge clk) disable iff (reset) pin_chg |=> !conversion_done_irq_q && stale_q;
  endproperty
  a_chg: assert property (p_chg) else $error("result stored after pin change");
  property p_conflict;
    @(posedge clk) disable iff (reset) end_w && (wr_ctl0 || wr_apc) |=> $stable(result_q);
  endproperty
  a_conflict: assert property (p_conflict) else $error("write lost to conversion end");
  property p_par;
    @(posedge clk) disable iff (reset)
      end_w && !first_q && ctl1_q.parallel |=> cnt_q == CNT_QTR;
  endproperty
  a_par: assert property (p_par) else $error("parallel period wrong");
  property p_hold;
    @(posedge clk) disable iff (reset) !store |=> $stable(result_q);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without store");
endmodule

// >>> tb/tb_delta_sigma_adc_control.sv
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module tb_delta_sigma_adc_control
  import dsc_pkg::*;
;
  localparam int CONV = 8;
  logic        clk         = 1'b0;
  logic        reset       = 1'b1;
  dsc_bus_s    bus         = '0;
  logic [15:0] sample_code = 16'h0000;
  logic [7:0]  rdata_q, pin_out_en_q, sar_pin_sel_q, ds_pin_sel_q, rv;
  logic [2:0]  sampling_delay_q;
  logic        neg_pin_ground_q, pwr_on_q, conversion_done_irq_q, result_guaranteed_q;
  dsc_mode_s   mode_q;
  logic [15:0] res, exp_res;
  int          failures = 0;
  int          checks   = 0;
  int          cycles   = 0;
  int          seed     = 32'hfcf01c0f;
  int          n;

  always #12.5 clk = ~clk;

  dsc_top #(.CONV_CYCLES(CONV)) u_dut (
    .clk                   (clk),
    .reset                 (reset),
    .bus                   (bus),
    .rdata_q               (rdata_q),
    .sample_code           (sample_code),
    .pin_out_en_q          (pin_out_en_q),
    .sar_pin_sel_q         (sar_pin_sel_q),
    .ds_pin_sel_q          (ds_pin_sel_q),
    .neg_pin_ground_q      (neg_pin_ground_q),
    .mode_q                (mode_q),
    .pwr_on_q              (pwr_on_q),
    .sampling_delay_q      (sampling_delay_q),
    .conversion_done_irq_q (conversion_done_irq_q),
    .result_guaranteed_q   (result_guaranteed_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      conclude();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // reference model: offset binary in differential mode, raw code otherwise
  function automatic int model_res(input int diff, input int code);
    return (diff != 0) ? (code ^ `DSC_HALF_SCALE) : code;
  endfunction

  // strobes go up at one falling edge and down at the next, so the taking edge sits between
  // every access is one byte at one direct address
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = '{a, 1'b1, 1'b0, d};
    @(negedge clk);
    bus.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    bus = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk);
    bus.rd = 1'b0;
    d = rdata_q;
  endtask

  task automatic rres(output logic [15:0] r);
    rd(`DSC_ADDR_RES_L, r[7:0]);
    rd(`DSC_ADDR_RES_H, r[15:8]);
  endtask

  // counts falling edges until the completion pulse, giving up at lim
  task automatic wait_irq(input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (conversion_done_irq_q !== 1'b1 && k < lim);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    rd(`DSC_ADDR_DIR, rv);
    chk8(rv, 8'hff);
    chk8(pin_out_en_q, 8'h00);
    rd(`DSC_ADDR_APC, rv);
    chk8(rv, 8'h08);
    rd(`DSC_ADDR_DLY, rv);
    chk8(rv, 8'h20);
    rd(16'h0000, rv);
    chk8(rv, 8'h00);
    for (int i = 0; i < 4; i++) begin
      exp_res = 16'($random(seed));
      wr(`DSC_ADDR_DIR, exp_res[7:0]);
      @(negedge clk);
      chk8(pin_out_en_q, ~exp_res[7:0]);
    end
    // delay field is locked until the enable bit is set
    wr(`DSC_ADDR_DLY, 8'h50);
    rd(`DSC_ADDR_DLY, rv);
    chk8(rv, 8'h20);
    wr(`DSC_ADDR_DLYEN, 8'h80);
    wr(`DSC_ADDR_DLY, 8'h50);
    @(negedge clk);
    chk8({5'h0, sampling_delay_q}, 8'h05);
    for (int i = 0; i < 8; i++) begin
      wr(`DSC_ADDR_CTL1, 8'(i));
      @(negedge clk);
      chk8({5'h0, mode_q}, {5'h0, i[0], i[1], i[2]});
      chk8({7'h0, neg_pin_ground_q}, {7'h0, ~i[0]});
    end
    // analog pins are made inputs before any channel is chosen
    wr(`DSC_ADDR_DIR, 8'hff);
    wr(`DSC_ADDR_APC, 8'h00);
    sample_code = 16'($random(seed));
    exp_res = 16'(model_res(1, sample_code));
    wr(`DSC_ADDR_CTL0, 8'h81);
    wr(`DSC_ADDR_CTL1, 8'h01);
    wr(`DSC_ADDR_CTL0, 8'hc1);
    // the enable registers inside the write; one edge to enter the run, then a full period
    wait_irq(40, n);
    chk8(8'(n), 8'(CONV + 1));
    chk8({7'h0, result_guaranteed_q}, 8'h00);
    chk8(ds_pin_sel_q, 8'h0c);
    chk8(sar_pin_sel_q, 8'h01);
    rres(res);
    chk16(res, exp_res);
    sample_code = 16'($random(seed));
    exp_res = 16'(model_res(1, sample_code));
    // the two result reads used four of the period's cycles
    wait_irq(40, n);
    chk8(8'(n), 8'(CONV - 4));
    rres(res);
    chk16(res, exp_res);
    wr(`DSC_ADDR_CTL0, 8'h81);
    wait_irq(30, n);
    chk8(8'(n), 8'd30);
    rres(res);
    chk16(res, exp_res);
    // power has been on long enough now
    wr(`DSC_ADDR_CTL0, 8'hc1);
    wait_irq(40, n);
    chk8(8'(n), 8'(CONV + 1));
    chk8({7'h0, result_guaranteed_q}, 8'h01);
    // a channel pin turned to output mid-run spoils every later result
    sample_code = ~sample_code;
    wr(`DSC_ADDR_DIR, 8'hf7);
    @(negedge clk);
    chk8({7'h0, ds_pin_sel_q[3]}, 8'h00);
    wait_irq(30, n);
    chk8(8'(n), 8'd30);
    rres(res);
    chk16(res, exp_res);
    wr(`DSC_ADDR_CTL0, 8'h81);
    wr(`DSC_ADDR_DIR, 8'hff);
    // control one is only touched while the sequence is stopped
    wr(`DSC_ADDR_CTL1, 8'h05);
    exp_res = 16'(model_res(1, sample_code));
    wr(`DSC_ADDR_CTL0, 8'hc1);
    wait_irq(40, n);
    chk8(8'(n), 8'(CONV + 1));
    for (int i = 0; i < 2; i++) begin
      wait_irq(40, n);
      chk8(8'(n), 8'(CONV / 4));
    end
    // the stop write lands on the next quarter-period end and must win over it
    sample_code = 16'($random(seed));
    wr(`DSC_ADDR_CTL0, 8'h81);
    rres(res);
    chk16(res, exp_res);
    wr(`DSC_ADDR_CTL1, 8'h00);
    sample_code = 16'($random(seed));
    exp_res = 16'(model_res(0, sample_code));
    wr(`DSC_ADDR_CTL0, 8'hc1);
    wait_irq(40, n);
    rres(res);
    chk16(res, exp_res);
    wr(`DSC_ADDR_CTL0, 8'h01);
    @(negedge clk);
    chk8({7'h0, pwr_on_q}, 8'h00);
    // a pin both converters claim goes to neither; digital pins go to none
    wr(`DSC_ADDR_SARSEL, 8'h02);
    @(negedge clk);
    chk8(ds_pin_sel_q, 8'h08);
    chk8(sar_pin_sel_q, 8'h00);
    wr(`DSC_ADDR_APC, 8'h04);
    wr(`DSC_ADDR_SARSEL, 8'h07);
    @(negedge clk);
    chk8(ds_pin_sel_q, 8'h00);
    chk8(sar_pin_sel_q, 8'h80);
    conclude();
  end
endmodule
